// ===== hdl/vpc_pkg.sv
// ****************************************
// vector placement control constants
// ****************************************
package vpc_pkg;

    // control register layout
    localparam int CTRL_W = 8;
    localparam int UNLOCK_BIT = 0;
    localparam int SEL_BIT = 1;
    localparam int PUD_BIT = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic SEL_RESET = 1'b0;
    localparam logic PUD_RESET = 1'b0;

    // unlock window length in core cycles
    localparam int UNLOCK_CYCLES = 4;
    localparam int CNT_W = 3;

    // program memory addressing, in words
    localparam int ADDR_W = 14;
    localparam int VEC_NUM_W = 6;
    localparam logic [13:0] FLASH_START = 14'h0000;
    localparam logic [13:0] BOOT_2K_BASE = 14'h1C00;
    localparam int FLASH_WORDS_DEF = 8192;
    localparam int BOOT_MIN_WORDS_DEF = 128;

    // fuse and lock bit encoding, zero means programmed
    localparam logic FUSE_PROGRAMMED = 1'b0;
    localparam logic [1:0] BOOT_SIZE_2K = 2'h0;
    localparam int FUSE_W = 5;

endpackage

// ===== hdl/vpc_unlock_if.sv
`timescale 1ns/1ps
// ****************************************
// unlock sequencer carrier
// ****************************************
interface vpc_unlock_if;
    // requests from the register side
    logic arm;
    logic sel_wr;
    logic instr_done;
    // sequencer state seen by the register side
    logic armed;
    logic mask;

    modport ctrl (output arm, output sel_wr, output instr_done, input armed, input mask);
    modport seq (input arm, input sel_wr, input instr_done, output armed, output mask);
endinterface

// ===== hdl/vpc_sync.sv
`timescale 1ns/1ps
// ****************************************
// three stage input synchroniser
// ****************************************
module vpc_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // asynchronous inputs and settled outputs
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_q
);
    import vpc_pkg::*;

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // one chain per bit, value taken once stages two and three agree
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                s1_q[i] <= 1'b0;
                s2_q[i] <= 1'b0;
                s3_q[i] <= 1'b0;
                sync_q[i] <= 1'b0;
            end else begin
                s1_q[i] <= async_in[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                if (s2_q[i] == s3_q[i]) begin
                    sync_q[i] <= s3_q[i];
                end
            end
        end
    end
endmodule

// ===== hdl/vpc_unlock.sv
`timescale 1ns/1ps
// ****************************************
// timed unlock sequencer
// ****************************************
module vpc_unlock (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register side
    vpc_unlock_if.seq u
);
    import vpc_pkg::*;

    typedef enum {VPC_IDLE, VPC_ARMED, VPC_HOLD} vpc_state_t;

    vpc_state_t state_q;
    vpc_state_t state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic cnt_zero;

    // decode of state for the register side
    assign cnt_zero = (cnt_q == '0);
    assign u.armed = (state_q == VPC_ARMED);
    assign u.mask = (state_q != VPC_IDLE);

    // next state: arm restarts, select write ends window early
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            VPC_IDLE: begin
                state_d = VPC_IDLE;
            end
            VPC_ARMED: begin
                if (u.sel_wr) begin
                    state_d = VPC_HOLD;
                end else if (cnt_zero) begin
                    state_d = VPC_IDLE;
                end else begin
                    cnt_d = cnt_q - CNT_W'(1);
                end
            end
            VPC_HOLD: begin
                if (u.instr_done) begin
                    state_d = VPC_IDLE;
                end
            end
            default: begin
                state_d = VPC_IDLE;
            end
        endcase
        if (u.arm) begin
            state_d = VPC_ARMED;
            cnt_d = CNT_W'(UNLOCK_CYCLES - 1);
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= VPC_IDLE;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // window checks
    window_len_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        u.arm ##1 (!u.arm && !u.sel_wr)[*3] |=> u.armed && u.mask)
        else $error("unlock window shorter than four cycles");
    window_end_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        u.arm ##1 (!u.arm && !u.sel_wr)[*4] |=> !u.armed && !u.mask)
        else $error("mask not released after unlock timeout");
    hold_mask_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        u.sel_wr && u.armed && !u.arm ##1 !u.instr_done |-> u.mask ##1 1'b1)
        else $error("mask dropped before following instruction");
endmodule

// ===== hdl/vpc_top.sv
`timescale 1ns/1ps
// Contract
// - with the select bit clear, vectors are fetched from the start of program flash.
// - with the select bit set, vectors move to the boot section base set by the size fuses.
// - acceptance is masked from the cycle unlock sets until the instruction after the select write completes.
// - with no select write, the mask is released four cycles after the unlock was set.
// - the automatic mask never alters the global interrupt enable flag.
// - hardware clears unlock after four cycles, or at once when select is written.
// - vectors in boot with the application lock programmed block irqs in the application.
// - vectors in application with the boot lock programmed block irqs in the boot section.
// - the pull-up disable bit turns off every pull-up of every port.
// - the smallest variant has no select or unlock bit and a fixed vector table.
// - with boot reset and a 2K boot section, reset sits at 0x1C00, vectors from 0x1C02 with select set.
// - the boot reset fuse picks reset at 0x000 or at the boot base, ignoring select.
module vpc_top #(
    parameter bit HAS_VECTOR_SELECT = 1'b1,
    parameter int FLASH_WORDS = vpc_pkg::FLASH_WORDS_DEF,
    parameter int BOOT_MIN_WORDS = vpc_pkg::BOOT_MIN_WORDS_DEF
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control register port
    input wire logic ctrl_wr,
    input wire logic [vpc_pkg::CTRL_W-1:0] ctrl_wdata,
    output logic [vpc_pkg::CTRL_W-1:0] ctrl_rdata_q,
    // fuses and lock bits
    input wire logic reset_to_boot_fuse,
    input wire logic [1:0] boot_size_fuses,
    input wire logic app_section_lock_bit,
    input wire logic boot_section_lock_bit,
    // core side
    input wire logic gie,
    input wire logic instr_done,
    input wire logic [vpc_pkg::ADDR_W-1:0] exec_pc,
    input wire logic [vpc_pkg::VEC_NUM_W-1:0] vector_num,
    output logic irq_enable_q,
    output logic [vpc_pkg::ADDR_W-1:0] vector_addr_q,
    // port side
    output logic pullup_global_disable_q
);
    import vpc_pkg::*;

    // ****************************************
    // fuse synchronisation
    // ****************************************

    logic [FUSE_W-1:0] fuse_raw;
    logic [FUSE_W-1:0] fuse_s;
    logic boot_rst_s;
    logic [1:0] boot_size_s;
    logic app_lock_s;
    logic boot_lock_s;

    // straps pass the three stage synchroniser
    assign fuse_raw = {reset_to_boot_fuse, boot_size_fuses,
                       app_section_lock_bit, boot_section_lock_bit};
    assign boot_rst_s = fuse_s[4];
    assign boot_size_s = fuse_s[3:2];
    assign app_lock_s = fuse_s[1];
    assign boot_lock_s = fuse_s[0];

    vpc_sync #(
        .W(FUSE_W)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(fuse_raw),
        .sync_q(fuse_s)
    );

    // ****************************************
    // unlock sequencer
    // ****************************************

    vpc_unlock_if uif ();

    vpc_unlock u_unlock (
        .clk(clk),
        .rst_n(rst_n),
        .u(uif.seq)
    );

    logic wr_unlock;
    logic wr_sel_val;
    logic wr_pud_val;
    logic arm;
    logic sel_wr;

    // write decode: unlock one arms, unlock zero inside window moves select
    assign wr_unlock = ctrl_wdata[UNLOCK_BIT];
    assign wr_sel_val = ctrl_wdata[SEL_BIT];
    assign wr_pud_val = ctrl_wdata[PUD_BIT];
    assign arm = HAS_VECTOR_SELECT && ctrl_wr && wr_unlock;
    assign sel_wr = ctrl_wr && !wr_unlock && uif.armed;
    assign uif.arm = arm;
    assign uif.sel_wr = sel_wr;
    assign uif.instr_done = instr_done;

    // ****************************************
    // control register
    // ****************************************

    logic sel_q;
    logic sel_d;
    logic pud_d;

    // select moves only through the window, pull-up disable on any write
    assign sel_d = (sel_wr && HAS_VECTOR_SELECT) ? wr_sel_val : sel_q;
    assign pud_d = ctrl_wr ? wr_pud_val : pullup_global_disable_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= SEL_RESET;
            pullup_global_disable_q <= PUD_RESET;
        end else begin
            sel_q <= sel_d;
            pullup_global_disable_q <= pud_d;
        end
    end

    logic armed_d;
    logic arm_timeout;
    logic [CTRL_W-1:0] rdata_d;
    logic [CNT_W-1:0] win_cnt_q;

    // shadow of the sequencer window for the readback path
    assign arm_timeout = uif.armed && (win_cnt_q == '0);

    // readback image, reserved bits zero, unlock shows live window
    assign armed_d = arm || (uif.armed && !sel_wr && uif.mask && !arm_timeout);
    assign rdata_d = {{(CTRL_W-PUD_BIT-1){1'b0}}, pud_d, 2'h0, sel_d, armed_d};

    // shadow counter, reloaded on every unlock write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            win_cnt_q <= '0;
        end else if (arm) begin
            win_cnt_q <= CNT_W'(UNLOCK_CYCLES - 1);
        end else if (win_cnt_q != '0) begin
            win_cnt_q <= win_cnt_q - CNT_W'(1);
        end
    end

    // readback register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_rdata_q <= CTRL_RESET;
        end else begin
            ctrl_rdata_q <= rdata_d;
        end
    end

    // ****************************************
    // vector placement
    // ****************************************

    logic [ADDR_W-1:0] boot_start;
    logic [ADDR_W-1:0] vec_base;
    logic [ADDR_W-1:0] vec_off;
    logic [ADDR_W-1:0] reset_addr;
    logic [ADDR_W-1:0] vec_addr_d;
    logic [1:0] size_shift;

    // boot base grows down from the top as size fuses are programmed
    assign size_shift = ~boot_size_s;
    assign boot_start = ADDR_W'(FLASH_WORDS - (BOOT_MIN_WORDS << size_shift));
    assign vec_base = sel_q ? boot_start : FLASH_START;
    assign vec_off = ADDR_W'({vector_num, 1'b0});
    assign reset_addr = (boot_rst_s == FUSE_PROGRAMMED) ? boot_start : FLASH_START;
    assign vec_addr_d = (vector_num == '0) ? reset_addr : vec_base + vec_off;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vector_addr_q <= FLASH_START;
        end else begin
            vector_addr_q <= vec_addr_d;
        end
    end

    // ****************************************
    // interrupt acceptance
    // ****************************************

    logic in_boot;
    logic sect_block;
    logic seq_block;
    logic irq_en_d;

    // section lock blocking and unlock masking, flag itself untouched
    assign in_boot = (exec_pc >= boot_start);
    assign sect_block = (sel_q && app_lock_s == FUSE_PROGRAMMED && !in_boot)
        || (!sel_q && boot_lock_s == FUSE_PROGRAMMED && in_boot);
    assign seq_block = arm || (uif.mask && !(uif.armed && arm_timeout && !sel_wr));
    assign irq_en_d = gie && !seq_block && !sect_block;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_enable_q <= 1'b0;
        end else begin
            irq_enable_q <= irq_en_d;
        end
    end

    // ****************************************
    // checks
    // ****************************************

    sel_locked_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        ctrl_wr && !uif.armed |=> sel_q == $past(sel_q))
        else $error("select changed outside unlock window");
    sel_write_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        sel_wr && HAS_VECTOR_SELECT |=> sel_q == $past(wr_sel_val))
        else $error("select not taken inside unlock window");
    no_select_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !HAS_VECTOR_SELECT |-> !sel_q && !ctrl_rdata_q[UNLOCK_BIT])
        else $error("select present in fixed variant");
    app_base_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !sel_q && vector_num != '0 |=> vector_addr_q == ADDR_W'({$past(vector_num), 1'b0}))
        else $error("vector not at start of flash");
    boot_base_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        sel_q && vector_num != '0 |=> vector_addr_q == $past(boot_start) + $past(vec_off))
        else $error("vector not at boot base");
    boot_2k_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        FLASH_WORDS == FLASH_WORDS_DEF && BOOT_MIN_WORDS == BOOT_MIN_WORDS_DEF
        && boot_size_s == BOOT_SIZE_2K |-> boot_start == BOOT_2K_BASE)
        else $error("2K boot base misplaced");
    reset_vec_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        vector_num == '0 && boot_rst_s != FUSE_PROGRAMMED |=> vector_addr_q == FLASH_START)
        else $error("reset vector moved with fuse unprogrammed");
    mask_start_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        arm |=> !irq_enable_q ##1 !irq_enable_q)
        else $error("irq accepted during unlock");
    mask_gie_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !gie |=> !irq_enable_q)
        else $error("irq accepted with global flag clear");
    unlock_clear_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        sel_wr && !arm |=> !ctrl_rdata_q[UNLOCK_BIT])
        else $error("unlock not cleared by select write");
    app_block_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        sel_q && app_lock_s == FUSE_PROGRAMMED && !in_boot |=> !irq_enable_q)
        else $error("irq in application with vectors in boot");
    boot_block_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !sel_q && boot_lock_s == FUSE_PROGRAMMED && in_boot |=> !irq_enable_q)
        else $error("irq in boot with vectors in application");
    pud_out_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        ctrl_wr |=> pullup_global_disable_q == $past(wr_pud_val)
        && ctrl_rdata_q[PUD_BIT] == $past(wr_pud_val))
        else $error("pull-up disable not following write");

    // ****************************************
    // sequencer hand-off and corner checks
    // ****************************************

    reset_boot_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        vector_num == '0 && boot_rst_s == FUSE_PROGRAMMED
        |=> vector_addr_q == $past(boot_start))
        else $error("reset vector not at boot base");
    vec_2k_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        FLASH_WORDS == FLASH_WORDS_DEF && BOOT_MIN_WORDS == BOOT_MIN_WORDS_DEF && sel_q
        && boot_size_s == BOOT_SIZE_2K && vector_num != '0
        |=> vector_addr_q == BOOT_2K_BASE + $past(vec_off))
        else $error("2K vector table not after boot base");
    hold_irq_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        uif.mask && !uif.armed && !instr_done |=> !irq_enable_q)
        else $error("irq accepted before following instruction");
    hold_end_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        uif.mask && !uif.armed && instr_done && !arm |=> !uif.mask)
        else $error("mask kept after following instruction");
    timeout_release_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        uif.armed && arm_timeout && !sel_wr && !arm && gie && !sect_block |=> irq_enable_q)
        else $error("acceptance not back after unlock timeout");
    unlock_read_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        arm |=> ctrl_rdata_q[UNLOCK_BIT] && uif.armed)
        else $error("unlock not shown after unlock write");
    arm_window_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        arm |=> uif.mask)
        else $error("mask not raised by unlock write");
    sel_hold_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !sel_wr |=> sel_q == $past(sel_q))
        else $error("select moved without window write");
    pud_hold_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !ctrl_wr |=> pullup_global_disable_q == $past(pullup_global_disable_q))
        else $error("pull-up disable moved without write");
    small_mask_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !HAS_VECTOR_SELECT |-> !uif.mask && !uif.armed)
        else $error("unlock sequence active in fixed variant");
endmodule

// ===== tb/vpc_core_model.sv
`timescale 1ns/1ps
// ****************************************
// core stand-in: i/o writes and instruction flow
// ****************************************
module vpc_core_model (
    // clock
    input wire logic clk,
    // register write port
    output logic ctrl_wr,
    output logic [vpc_pkg::CTRL_W-1:0] ctrl_wdata,
    // instruction flow
    output logic instr_done
);
    import vpc_pkg::*;

    // idle bus at time zero
    initial begin
        ctrl_wr = 1'b0;
        ctrl_wdata = 8'h00;
        instr_done = 1'b0;
    end

    // one i/o write, held across exactly one sampling edge
    task automatic io_write(input logic [7:0] d);
        @(posedge clk);
        #2;
        ctrl_wr = 1'b1;
        ctrl_wdata = d;
        @(posedge clk);
        #2;
        ctrl_wr = 1'b0;
        ctrl_wdata = ~d; // released data shows no stale value
    endtask

    // unlock, then select write two edges later, inside the window
    task automatic move_vectors(input logic sel);
        io_write(8'h01);
        io_write({6'h00, sel, 1'b0});
    endtask

    // one completed instruction
    task automatic step();
        @(posedge clk);
        #2;
        instr_done = 1'b1;
        @(posedge clk);
        #2;
        instr_done = 1'b0;
    endtask
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import vpc_pkg::*;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ctrl_wr, instr_done, gie, reset_to_boot_fuse, app_section_lock_bit;
    logic boot_section_lock_bit, irq_enable_q, irq_s, pud_q, pud_s;
    logic [7:0] ctrl_wdata, ctrl_rdata_q, rdata_s;
    logic [1:0] boot_size_fuses;
    logic [13:0] exec_pc, vector_addr_q, vaddr_s;
    logic [5:0] vector_num;
    logic [31:0] rng = 32'habfa_28a6;
    int error_cnt = 0;
    int n_checks = 0;

    // ****************************************
    // clock, core model, designs
    // ****************************************
    always #12.5 clk = ~clk;

    vpc_core_model core (.clk(clk), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
        .instr_done(instr_done));

    vpc_top dut (.clk(clk), .rst_n(rst_n), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
        .ctrl_rdata_q(ctrl_rdata_q), .reset_to_boot_fuse(reset_to_boot_fuse),
        .boot_size_fuses(boot_size_fuses), .app_section_lock_bit(app_section_lock_bit),
        .boot_section_lock_bit(boot_section_lock_bit), .gie(gie), .instr_done(instr_done),
        .exec_pc(exec_pc), .vector_num(vector_num), .irq_enable_q(irq_enable_q),
        .vector_addr_q(vector_addr_q), .pullup_global_disable_q(pud_q));

    // smallest variant: no select, no unlock
    vpc_top #(.HAS_VECTOR_SELECT(1'b0)) dut_small (.clk(clk), .rst_n(rst_n),
        .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .ctrl_rdata_q(rdata_s),
        .reset_to_boot_fuse(reset_to_boot_fuse), .boot_size_fuses(boot_size_fuses),
        .app_section_lock_bit(app_section_lock_bit),
        .boot_section_lock_bit(boot_section_lock_bit), .gie(gie), .instr_done(instr_done),
        .exec_pc(exec_pc), .vector_num(vector_num), .irq_enable_q(irq_s),
        .vector_addr_q(vaddr_s), .pullup_global_disable_q(pud_s));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    function automatic logic [13:0] boot_base(input logic [1:0] f);
        return 14'(FLASH_WORDS_DEF - (BOOT_MIN_WORDS_DEF << (3 - f)));
    endfunction

    // expected vector word address
    function automatic logic [13:0] vec_exp(input logic sel, input logic rf,
        input logic [1:0] f, input logic [5:0] n);
        logic [13:0] b;
        b = boot_base(f);
        if (n == 6'h00) begin
            return (rf == FUSE_PROGRAMMED) ? b : FLASH_START;
        end
        return (sel ? b : FLASH_START) + {7'h00, n, 1'b0};
    endfunction

    // expected acceptance for one placement, flag, lock bits and position
    function automatic logic irq_exp(input logic sel, input logic g, input logic al,
        input logic bl, input logic [13:0] pc);
        logic ib;
        ib = (pc >= boot_base(BOOT_SIZE_2K));
        return g && !(sel && al == FUSE_PROGRAMMED && !ib)
            && !(!sel && bl == FUSE_PROGRAMMED && ib);
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // watchdog, generous against roughly 700 cycles of tests
    initial begin
        #(4000 * 25);
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        finish_test();
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        logic [31:0] r;
        gie = 1'b1;
        reset_to_boot_fuse = 1'b1;
        boot_size_fuses = BOOT_SIZE_2K;
        app_section_lock_bit = 1'b1;
        boot_section_lock_bit = 1'b1;
        exec_pc = 14'h0000;
        vector_num = 6'h00;
        repeat (2) @(posedge clk);
        #2;
        rst_n = 1'b1;
        tick(5);
        chk(ctrl_rdata_q, CTRL_RESET, "reset value");
        chk(pud_q, PUD_RESET, "pull-up disable reset");
        $display("test reset done");

        // select written while not armed, reserved bits written high
        core.io_write(8'hfe);
        tick(1);
        chk(ctrl_rdata_q, 8'h10, "unarmed select write");
        chk(pud_q, 1'b1, "pull-up disable set");
        chk(rdata_s, 8'h10, "small variant readback");
        chk(pud_s, 1'b1, "small variant pull-up disable");
        core.io_write(8'h00);
        tick(1);
        chk(pud_q, 1'b0, "pull-up disable clear");
        $display("test register done");

        // unlock with no select write: four masked cycles, then release
        core.io_write(8'h01);
        for (int i = 0; i < 4; i++) begin
            chk(ctrl_rdata_q[0], 1'b1, "unlock window open");
            chk(irq_enable_q, 1'b0, "masked in window");
            tick(1);
        end
        chk(ctrl_rdata_q[0], 1'b0, "unlock timed out");
        chk(irq_enable_q, 1'b1, "mask released");
        chk(rdata_s, 8'h00, "small variant no unlock");
        $display("test timeout done");

        // move to boot: mask held until the next instruction completes
        core.move_vectors(1'b1);
        tick(1);
        chk(ctrl_rdata_q, 8'h02, "select moved, unlock cleared");
        for (int i = 0; i < 3; i++) begin
            chk(irq_enable_q, 1'b0, "held until next instruction");
            tick(1);
        end
        core.step();
        tick(1);
        chk(irq_enable_q, 1'b1, "acceptance back with gie kept");
        chk(rdata_s, 8'h00, "small variant select absent");
        $display("test move done");

        // vector addresses for random fuses and indices, both placements
        for (int s = 1; s >= 0; s--) begin
            if (s == 0) begin
                core.move_vectors(1'b0);
                core.step();
            end
            for (int k = 0; k < 40; k++) begin
                r = xs();
                boot_size_fuses = (k < 2) ? BOOT_SIZE_2K : r[1:0];
                reset_to_boot_fuse = (k < 2) ? FUSE_PROGRAMMED : r[2];
                vector_num = (k < 2) ? 6'(k) : r[8:3];
                tick(6);
                chk(vector_addr_q, vec_exp(s[0], reset_to_boot_fuse, boot_size_fuses,
                    vector_num), "vector address");
                chk(vaddr_s, vec_exp(1'b0, reset_to_boot_fuse, boot_size_fuses,
                    vector_num), "small variant vector");
            end
        end
        $display("test vectors done");

        // section blocking at the boot boundary, both placements
        boot_size_fuses = BOOT_SIZE_2K;
        for (int i = 0; i < 4; i++) begin
            if (i == 2) begin
                core.move_vectors(1'b1);
                core.step();
            end
            app_section_lock_bit = ~i[1];
            boot_section_lock_bit = i[1];
            exec_pc = boot_base(BOOT_SIZE_2K) - 14'(i[0]);
            tick(6);
            chk(irq_enable_q, i[0] ^ i[1], "section block");
        end
        gie = 1'b0;
        tick(2);
        chk(irq_enable_q, 1'b0, "gie low blocks");

        // random flag, lock bits and position, boundary first
        for (int k = 0; k < 24; k++) begin
            r = xs();
            gie = r[0];
            app_section_lock_bit = r[1];
            boot_section_lock_bit = r[2];
            exec_pc = (k < 2) ? boot_base(BOOT_SIZE_2K) - 14'(k) : r[16:3];
            tick(6);
            chk(irq_enable_q, irq_exp(1'b1, gie, app_section_lock_bit, boot_section_lock_bit,
                exec_pc), "random section block");
            chk(irq_s, irq_exp(1'b0, gie, app_section_lock_bit, boot_section_lock_bit,
                exec_pc), "small variant section block");
        end
        $display("test sections done");
        finish_test();
    end
endmodule
